// ### hdl/dmc_dev.sv
// converter end: word capture, A..D serialiser, response mode, data clock, calibration
// assumes the data source shares CLK and times its words from the exported data clock
//
// Summary of operation
// R1: rising calibrate trigger starts a calibration
// R2: source raises trigger only after supplies settle
// R3: source holds words static during calibration
// R4: calibration ends within 65535 clock cycles
// R5: trigger kept high keeps calibration valid
// R6: new calibration after clock stop or power
// R7: two pins decode NRZ, RZ or RF
// R8: default NRZ holds sample whole period
// R9: RZ shows sample then midscale half
// R10: RF shows sample then inverted half
// R11: four 12-bit offset-binary channels, MSB highest
// R12: capture four words every four cycles
// R13: data clock is word rate over 4/2
// R14: divide 1 captures at 0 and 180
// R15: divide 0 captures at quarter points
// R16: skew delays data clock half word period
// R17: skew leaves internal capture timing alone
// R18: source aligns to unskewed capture instants
// R19: skew equals two converter clock cycles
// R20: data clock is CLK over 8 or 16
// R21: clock selects default to zero
// R22: send A, then B, C, D
// R23: source waits 65536 cycles before streaming
`timescale 1ns/1ps
`default_nettype none
module dmc_dev #(
  parameter int CAL_CYCLES = dmc_pkg::CAL_CYCLES_DEF
) (
  // clock, reset, enable
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic CE,
  // pins toward the data source
  dmc_link_if.dev LINK,
  // converter core side
  output logic [dmc_pkg::WORD_W-1:0] SAMPLE_FIRST_HALF,
  output logic [dmc_pkg::WORD_W-1:0] SAMPLE_SECOND_HALF,
  output logic SAMPLE_VALID,
  output dmc_pkg::dmc_mode_t RESPONSE_MODE,
  output logic CAL_BUSY,
  output logic TERM_CALIBRATED
);
  import dmc_pkg::*;

  localparam logic [CAL_CNT_W-1:0] CAL_LAST = CAL_CNT_W'(CAL_CYCLES - 1);

  // ==========================================================
  // pin synchronisers
  logic [SYNC_W-1:0] pin_raw;
  logic [SYNC_W-1:0] sync1_q;
  logic [SYNC_W-1:0] sync2_q;
  logic [SYNC_W-1:0] sync3_q;
  logic [SYNC_W-1:0] pin_q;
  logic [SYNC_W-1:0] pin_d;

  assign pin_raw[PIN_CAL] = LINK.calibrate_trigger;
  assign pin_raw[PIN_RZ] = LINK.return_zero_select;
  assign pin_raw[PIN_RF] = LINK.doublet_select;
  assign pin_raw[PIN_DIV] = LINK.clock_divide_select;
  assign pin_raw[PIN_SKEW] = LINK.data_clock_skew_select;

  // a lane rises only once stages two and three agree high, and drops as soon as they differ
  assign pin_d = (sync2_q & sync3_q) | (pin_q & ~(sync2_q ^ sync3_q));

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      sync1_q <= SYNC_ZERO;
      sync2_q <= SYNC_ZERO;
      sync3_q <= SYNC_ZERO;
      pin_q <= SYNC_ZERO; // see R21
    end else if (CE) begin
      sync1_q <= pin_raw;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      pin_q <= pin_d;
    end
  end

  // ==========================================================
  // calibration sequencer
  dmc_cal_t cal_q;
  logic cal_prev_q;
  logic [CAL_CNT_W-1:0] cal_cnt_q;
  logic cal_rise;

  assign cal_rise = pin_q[PIN_CAL] & ~cal_prev_q; // see R1

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      cal_q <= CAL_IDLE;
      cal_prev_q <= 1'b0;
      cal_cnt_q <= CAL_CNT_ZERO;
      CAL_BUSY <= 1'b0;
      TERM_CALIBRATED <= 1'b0;
    end else if (CE) begin
      cal_prev_q <= pin_q[PIN_CAL];
      case (cal_q)
        CAL_IDLE: begin
          if (cal_rise) begin
            cal_q <= CAL_RUN; // see R1
            cal_cnt_q <= CAL_CNT_ZERO;
            CAL_BUSY <= 1'b1;
            TERM_CALIBRATED <= 1'b0;
          end
        end
        CAL_RUN: begin
          // dropping the trigger mid-run abandons the attempt
          if (!pin_q[PIN_CAL]) begin
            cal_q <= CAL_IDLE; // see R5
            CAL_BUSY <= 1'b0;
          end else if (cal_cnt_q == CAL_LAST) begin
            cal_q <= CAL_HELD; // see R4
            CAL_BUSY <= 1'b0;
            TERM_CALIBRATED <= 1'b1;
          end else begin
            cal_cnt_q <= cal_cnt_q + CAL_CNT_STEP;
          end
        end
        CAL_HELD: begin
          if (!pin_q[PIN_CAL]) begin
            cal_q <= CAL_IDLE; // see R5
            TERM_CALIBRATED <= 1'b0;
          end
        end
        default: begin
          cal_q <= CAL_IDLE;
          CAL_BUSY <= 1'b0;
          TERM_CALIBRATED <= 1'b0;
        end
      endcase
    end
  end

  // ==========================================================
  // response mode decode
  dmc_mode_t mode_d;

  always_comb begin
    case ({pin_q[PIN_RF], pin_q[PIN_RZ]})
      2'b01: mode_d = MODE_RZ; // see R7
      2'b10: mode_d = MODE_RF; // see R7
      // the forbidden both-high case also falls back to NRZ
      default: mode_d = MODE_NRZ; // see R8
    endcase
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      RESPONSE_MODE <= MODE_NRZ; // see R8
    end else if (CE) begin
      RESPONSE_MODE <= mode_d;
    end
  end

  // ==========================================================
  // divider and exported data clock
  logic [DIV_W-1:0] div_cnt_q;
  logic clk_raw;
  logic dly1_q;
  logic dly2_q;
  logic ssc_q;
  logic ssc_n_q;
  logic ssc_d;

  // high half of the period starts on a capture instant
  assign clk_raw = pin_q[PIN_DIV] ? ~div_cnt_q[DIV8_BIT] : ~div_cnt_q[DIV16_BIT]; // see R13 R20
  // skew taps a two-stage delay, never the capture counter
  assign ssc_d = pin_q[PIN_SKEW] ? dly2_q : clk_raw; // see R16 R17 R19

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      div_cnt_q <= {DIV_W{1'b0}};
      dly1_q <= 1'b0;
      dly2_q <= 1'b0;
      ssc_q <= 1'b0;
      ssc_n_q <= 1'b1;
    end else if (CE) begin
      div_cnt_q <= div_cnt_q + DIV_STEP;
      dly1_q <= clk_raw;
      dly2_q <= dly1_q; // see R19
      ssc_q <= ssc_d;
      ssc_n_q <= ~ssc_d;
    end
  end

  assign LINK.source_sync_clock_pos = ssc_q;
  assign LINK.source_sync_clock_neg = ssc_n_q;

  // ==========================================================
  // word capture and A..D serialiser
  logic capture;
  logic [3*WORD_W-1:0] hold_q;
  logic [WORD_W-1:0] cur;

  // capture cadence is the unskewed counter, one word slot in four
  assign capture = (div_cnt_q[1:0] == CAP_PHASE); // see R12 R14 R15 R17
  assign cur = capture ? LINK.chan_a_word_pos : hold_q[3*WORD_W-1:2*WORD_W]; // see R22

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      hold_q <= {3{WORD_ZERO}};
      SAMPLE_VALID <= 1'b0;
    end else if (CE) begin
      if (capture) begin
        hold_q <= {LINK.chan_b_word_pos, LINK.chan_c_word_pos, LINK.chan_d_word_pos}; // see R11 R22
        SAMPLE_VALID <= 1'b1;
      end else begin
        hold_q <= {hold_q[2*WORD_W-1:0], WORD_ZERO}; // see R22
      end
    end
  end

  // ==========================================================
  // half-period shaping
  // offset binary: bitwise inversion mirrors about midscale
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      SAMPLE_FIRST_HALF <= MIDSCALE;
      SAMPLE_SECOND_HALF <= MIDSCALE;
    end else if (CE) begin
      SAMPLE_FIRST_HALF <= cur;
      case (mode_d)
        MODE_RZ: SAMPLE_SECOND_HALF <= MIDSCALE; // see R9
        MODE_RF: SAMPLE_SECOND_HALF <= ~cur; // see R10
        MODE_NRZ: SAMPLE_SECOND_HALF <= cur; // see R8
        default: SAMPLE_SECOND_HALF <= cur;
      endcase
    end
  end

endmodule : dmc_dev
`default_nettype wire

// ### hdl/dmc_pkg.sv
// shared constants and types for the converter input mux, mode and calibration ends
// assumes both ends run on the same converter clock
package dmc_pkg;

  // ==========================================================
  // data path
  localparam int WORD_W = 12;
  localparam int NUM_CH = 4;
  localparam int GROUP_W = WORD_W * NUM_CH;
  localparam int CH_A_LSB = 0;
  localparam int CH_B_LSB = WORD_W;
  localparam int CH_C_LSB = 2 * WORD_W;
  localparam int CH_D_LSB = 3 * WORD_W;
  localparam logic [WORD_W-1:0] MIDSCALE = 12'h800;
  localparam logic [WORD_W-1:0] WORD_ZERO = 12'h000;
  localparam logic [GROUP_W-1:0] GROUP_ZERO = 48'h0000_0000_0000;

  // ==========================================================
  // clock division and capture cadence
  localparam int DIV_W = 4;
  localparam int DIV8_BIT = 2;
  localparam int DIV16_BIT = 3;
  localparam logic [DIV_W-1:0] DIV_STEP = 4'h1;
  localparam logic [1:0] CAP_PHASE = 2'h0;
  localparam int SKEW_CYCLES = 2;

  // ==========================================================
  // calibration timing, in converter clock cycles
  localparam int CAL_CNT_W = 17;
  // five cycles of trigger sync latency come on top of this count
  localparam int CAL_CYCLES_DEF = 65530;
  localparam int CAL_WAIT_DEF = 65536;
  localparam logic [CAL_CNT_W-1:0] CAL_CNT_ZERO = 17'h00000;
  localparam logic [CAL_CNT_W-1:0] CAL_CNT_STEP = 17'h00001;

  // ==========================================================
  // pin synchroniser lanes
  localparam int SYNC_W = 5;
  localparam int PIN_CAL = 0;
  localparam int PIN_RZ = 1;
  localparam int PIN_RF = 2;
  localparam int PIN_DIV = 3;
  localparam int PIN_SKEW = 4;
  localparam logic [SYNC_W-1:0] SYNC_ZERO = 5'h00;

  // ==========================================================
  // source word phase tracking
  localparam logic [1:0] PHASE_LOCK_NOSKEW = 2'h0;
  localparam logic [1:0] PHASE_LOCK_SKEW = 2'h2;
  localparam logic [1:0] UPDATE_PHASE = 2'h1;
  localparam logic [1:0] PHASE_STEP = 2'h1;
  localparam int FIFO_DEPTH = 2;
  localparam logic [1:0] FIFO_CNT_FULL = 2'h2;
  localparam logic [1:0] FIFO_CNT_STEP = 2'h1;

  typedef enum logic [2:0] {
    MODE_NRZ = 3'b001,
    MODE_RZ = 3'b010,
    MODE_RF = 3'b100
  } dmc_mode_t;

  typedef enum logic [2:0] {
    CAL_IDLE = 3'b001,
    CAL_RUN = 3'b010,
    CAL_HELD = 3'b100
  } dmc_cal_t;

endpackage : dmc_pkg

// ### hdl/dmc_link_if.sv
// pin bundle between the data source and the converter's digital side
// assumes the source end drives the two clock select pins low out of reset
`timescale 1ns/1ps
`default_nettype none
interface dmc_link_if;
  import dmc_pkg::*;
  logic [WORD_W-1:0] chan_a_word_pos;
  logic [WORD_W-1:0] chan_b_word_pos;
  logic [WORD_W-1:0] chan_c_word_pos;
  logic [WORD_W-1:0] chan_d_word_pos;
  logic calibrate_trigger;
  logic return_zero_select;
  logic doublet_select;
  logic clock_divide_select;
  logic data_clock_skew_select;
  logic source_sync_clock_pos;
  logic source_sync_clock_neg;

  modport dev (
    input chan_a_word_pos, chan_b_word_pos, chan_c_word_pos, chan_d_word_pos,
    input calibrate_trigger, return_zero_select, doublet_select,
    input clock_divide_select, data_clock_skew_select,
    output source_sync_clock_pos, source_sync_clock_neg
  );

  modport src (
    output chan_a_word_pos, chan_b_word_pos, chan_c_word_pos, chan_d_word_pos,
    output calibrate_trigger, return_zero_select, doublet_select,
    output clock_divide_select, data_clock_skew_select,
    input source_sync_clock_pos, source_sync_clock_neg
  );
endinterface : dmc_link_if
`default_nettype wire

// ### hdl/dmc_src.sv
// data source end: group buffer, word launch paced by the data clock, pin control
// assumes the converter end shares CLK; only the data clock is resynchronised
`timescale 1ns/1ps
`default_nettype none
module dmc_src #(
  parameter int CAL_WAIT = dmc_pkg::CAL_WAIT_DEF
) (
  // clock, reset, enable
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic CE,
  // pins toward the converter
  dmc_link_if.src LINK,
  // user control
  input wire logic CAL_ENABLE,
  input wire logic MODE_REQ_RZ,
  input wire logic MODE_REQ_RF,
  input wire logic DIV_SEL,
  input wire logic SKEW_SEL,
  // user data stream, channel A in the low word
  input wire logic [dmc_pkg::GROUP_W-1:0] GROUP_DATA,
  input wire logic GROUP_VALID,
  output logic GROUP_READY,
  // status
  output logic CAL_READY,
  output logic LOCKED
);
  import dmc_pkg::*;

  localparam logic [CAL_CNT_W-1:0] WAIT_LAST = CAL_CNT_W'(CAL_WAIT - 1);

  // ==========================================================
  // static control pins
  logic trig_q;
  logic rz_q;
  logic rf_q;
  logic div_q;
  logic skew_q;

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      trig_q <= 1'b0;
      rz_q <= 1'b0;
      rf_q <= 1'b0;
      div_q <= 1'b0;
      skew_q <= 1'b0;
    end else if (CE) begin
      // user raises CAL_ENABLE only once supplies are steady
      trig_q <= CAL_ENABLE; // see R2 R5 R6
      rz_q <= MODE_REQ_RZ & ~MODE_REQ_RF; // see R7
      rf_q <= MODE_REQ_RF & ~MODE_REQ_RZ; // see R7
      div_q <= DIV_SEL;
      skew_q <= SKEW_SEL;
    end
  end

  assign LINK.calibrate_trigger = trig_q;
  assign LINK.return_zero_select = rz_q;
  assign LINK.doublet_select = rf_q;
  assign LINK.clock_divide_select = div_q;
  assign LINK.data_clock_skew_select = skew_q;

  // ==========================================================
  // calibration wait, no done indication comes back
  dmc_cal_t cw_q;
  logic [CAL_CNT_W-1:0] cw_cnt_q;

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      cw_q <= CAL_IDLE;
      cw_cnt_q <= CAL_CNT_ZERO;
      CAL_READY <= 1'b0;
    end else if (CE) begin
      case (cw_q)
        CAL_IDLE: begin
          if (CAL_ENABLE && !trig_q) begin
            cw_q <= CAL_RUN;
            cw_cnt_q <= CAL_CNT_ZERO;
          end
        end
        CAL_RUN: begin
          if (!CAL_ENABLE) begin
            cw_q <= CAL_IDLE;
          end else if (cw_cnt_q == WAIT_LAST) begin
            cw_q <= CAL_HELD; // see R23
            CAL_READY <= 1'b1;
          end else begin
            cw_cnt_q <= cw_cnt_q + CAL_CNT_STEP;
          end
        end
        CAL_HELD: begin
          if (!CAL_ENABLE) begin
            cw_q <= CAL_IDLE;
            CAL_READY <= 1'b0;
          end
        end
        default: begin
          cw_q <= CAL_IDLE;
          CAL_READY <= 1'b0;
        end
      endcase
    end
  end

  // ==========================================================
  // data clock resync and word phase
  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic lvl_q;
  logic rise;
  logic [1:0] phase_q;
  logic update;

  assign rise = s2_q & s3_q & ~lvl_q;
  assign update = (phase_q == UPDATE_PHASE);

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      lvl_q <= 1'b0;
      phase_q <= PHASE_LOCK_NOSKEW;
      LOCKED <= 1'b0;
    end else if (CE) begin
      s1_q <= LINK.source_sync_clock_pos & ~LINK.source_sync_clock_neg;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        lvl_q <= s2_q;
      end
      if (rise) begin
        // skewed clock rises two cycles late; aim at the unskewed instants
        phase_q <= skew_q ? PHASE_LOCK_SKEW : PHASE_LOCK_NOSKEW; // see R18
        LOCKED <= 1'b1;
      end else begin
        phase_q <= phase_q + PHASE_STEP;
      end
    end
  end

  // ==========================================================
  // two-entry group buffer and word launch
  logic [GROUP_W-1:0] mem_q [0:FIFO_DEPTH-1];
  logic wr_ptr_q;
  logic rd_ptr_q;
  logic [1:0] cnt_q;
  logic [1:0] cnt_d;
  logic push;
  logic pop;
  logic [GROUP_W-1:0] word_q;

  assign push = GROUP_VALID & GROUP_READY;
  // words stay frozen until calibration has had time to finish
  assign pop = update & LOCKED & CAL_READY & (cnt_q != 2'h0); // see R3 R23
  assign cnt_d = cnt_q + (push ? FIFO_CNT_STEP : 2'h0) - (pop ? FIFO_CNT_STEP : 2'h0);

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      wr_ptr_q <= 1'b0;
      rd_ptr_q <= 1'b0;
      cnt_q <= 2'h0;
      GROUP_READY <= 1'b1;
      word_q <= GROUP_ZERO;
    end else if (CE) begin
      if (push) begin
        mem_q[wr_ptr_q] <= GROUP_DATA;
        wr_ptr_q <= ~wr_ptr_q;
      end
      if (pop) begin
        // launch mid word period, away from every capture edge
        word_q <= mem_q[rd_ptr_q]; // see R14 R15
        rd_ptr_q <= ~rd_ptr_q;
      end
      cnt_q <= cnt_d;
      GROUP_READY <= (cnt_d != FIFO_CNT_FULL);
    end
  end

  // see R11
  assign LINK.chan_a_word_pos = word_q[CH_A_LSB +: WORD_W];
  assign LINK.chan_b_word_pos = word_q[CH_B_LSB +: WORD_W];
  assign LINK.chan_c_word_pos = word_q[CH_C_LSB +: WORD_W];
  assign LINK.chan_d_word_pos = word_q[CH_D_LSB +: WORD_W];

endmodule : dmc_src
`default_nettype wire

// ### tb/dmc_link_properties.sv
// pin-level checks between the data source and converter ends
// assumes one converter clock and a synchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
module dmc_link_properties (
  // clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic CE,
  // bundle pins
  input wire logic [dmc_pkg::WORD_W-1:0] chan_a_word_pos,
  input wire logic [dmc_pkg::WORD_W-1:0] chan_b_word_pos,
  input wire logic [dmc_pkg::WORD_W-1:0] chan_c_word_pos,
  input wire logic [dmc_pkg::WORD_W-1:0] chan_d_word_pos,
  input wire logic calibrate_trigger,
  input wire logic return_zero_select,
  input wire logic doublet_select,
  input wire logic clock_divide_select,
  input wire logic data_clock_skew_select,
  input wire logic source_sync_clock_pos,
  input wire logic source_sync_clock_neg
);
  import dmc_pkg::*;
  logic [GROUP_W-1:0] words;
  logic [1:0] sel_q;
  logic [5:0] quiet_q;
  logic [2:0] cyc_q;
  logic quiet;
  logic ssc;
  assign words = {chan_d_word_pos, chan_c_word_pos, chan_b_word_pos, chan_a_word_pos};
  assign quiet = quiet_q == 6'h3F;
  assign ssc = source_sync_clock_pos;
  // ==================================================
  // helpers
  // select changes pass a synchroniser, so clock shape is judged only once settled
  always_ff @(posedge CLK) begin
    sel_q <= {clock_divide_select, data_clock_skew_select};
  end
  always_ff @(posedge CLK) begin
    if (!RST_N || sel_q != {clock_divide_select, data_clock_skew_select}) begin
      quiet_q <= 6'h00;
    end else if (!quiet) begin
      quiet_q <= quiet_q + 6'h01;
    end
  end
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      cyc_q <= 3'h0;
    end else if (CE) begin
      cyc_q <= cyc_q + 3'h1;
    end
  end
  // ==================================================
  // properties
  default clocking dmc_cb @(posedge CLK); endclocking
  default disable iff (!RST_N || !CE);
  property p_clk_pair;
    ssc != source_sync_clock_neg;
  endproperty
  a_clk_pair: assert property (p_clk_pair) else $error("data clock pair not complementary");
  property p_mode_excl;
    !(return_zero_select && doublet_select);
  endproperty
  a_mode_excl: assert property (p_mode_excl) else $error("both mode pins high");
  // a select change aborts a shape check already in flight
  property p_div8;
    disable iff (!RST_N || !CE || !quiet)
    quiet && clock_divide_select && $rose(ssc) |-> ssc[*4] ##1 !ssc[*4] ##1 ssc;
  endproperty
  a_div8: assert property (p_div8) else $error("data clock not CLK over 8");
  property p_div16;
    disable iff (!RST_N || !CE || !quiet)
    quiet && !clock_divide_select && $rose(ssc) |-> ssc[*8] ##1 !ssc[*8] ##1 ssc;
  endproperty
  a_div16: assert property (p_div16) else $error("data clock not CLK over 16");
  property p_phase;
    quiet && $rose(ssc) |-> cyc_q == (data_clock_skew_select ? 3'h3 : 3'h1);
  endproperty
  a_phase: assert property (p_phase) else $error("data clock rise at wrong phase");
  property p_word_pace;
    $changed(words) |=> $stable(words)[*3];
  endproperty
  a_word_pace: assert property (p_word_pace) else $error("words changed faster than one group per 4");
  property p_cal_quiet;
    $rose(calibrate_trigger) |=> $stable(words)[*8];
  endproperty
  a_cal_quiet: assert property (p_cal_quiet) else $error("words moved during calibration");
  property p_idle_hold;
    (!calibrate_trigger)[*2] |=> $stable(words);
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("words moved without calibration");
endmodule : dmc_link_properties
`default_nettype wire

// ### tb/tb_dac_input_mux_mode_and_cal.sv
// bench: source and converter ends joined through the pin bundle
// assumes shortened calibration counts; one bench enable drives CE on both ends
`timescale 1ns/1ps
`default_nettype none
module tb_dac_input_mux_mode_and_cal;
  import dmc_pkg::*;
  localparam int CALC = 20;
  localparam int CALW = 26;
  typedef struct {
    logic rz;
    logic rf;
    logic div;
    logic skew;
    logic [GROUP_W-1:0] grp;
    dmc_mode_t mode;
  } dmc_row_t;
  logic clk, rst_n, cal_en, req_rz, req_rf, div_sel, skew_sel, grp_valid, ce;
  logic grp_ready, cal_ready, locked, s_valid, cal_busy, term_ok;
  logic [GROUP_W-1:0] grp_data;
  logic [WORD_W-1:0] s_first, s_second;
  dmc_mode_t mode;
  int err_total, tests_run;
  dmc_row_t rows [4];
  dmc_link_if dmc_link_if_inst ();
  dmc_dev #(.CAL_CYCLES(CALC)) dmc_dev_inst (
    .CLK(clk),
    .RST_N(rst_n),
    .CE(ce),
    .LINK(dmc_link_if_inst),
    .SAMPLE_FIRST_HALF(s_first),
    .SAMPLE_SECOND_HALF(s_second),
    .SAMPLE_VALID(s_valid),
    .RESPONSE_MODE(mode),
    .CAL_BUSY(cal_busy),
    .TERM_CALIBRATED(term_ok)
  );
  dmc_src #(.CAL_WAIT(CALW)) dmc_src_inst (
    .CLK(clk),
    .RST_N(rst_n),
    .CE(ce),
    .LINK(dmc_link_if_inst),
    .CAL_ENABLE(cal_en),
    .MODE_REQ_RZ(req_rz),
    .MODE_REQ_RF(req_rf),
    .DIV_SEL(div_sel),
    .SKEW_SEL(skew_sel),
    .GROUP_DATA(grp_data),
    .GROUP_VALID(grp_valid),
    .GROUP_READY(grp_ready),
    .CAL_READY(cal_ready),
    .LOCKED(locked)
  );
  dmc_link_properties dmc_link_properties_inst (
    .CLK(clk),
    .RST_N(rst_n),
    .CE(ce),
    .chan_a_word_pos(dmc_link_if_inst.chan_a_word_pos),
    .chan_b_word_pos(dmc_link_if_inst.chan_b_word_pos),
    .chan_c_word_pos(dmc_link_if_inst.chan_c_word_pos),
    .chan_d_word_pos(dmc_link_if_inst.chan_d_word_pos),
    .calibrate_trigger(dmc_link_if_inst.calibrate_trigger),
    .return_zero_select(dmc_link_if_inst.return_zero_select),
    .doublet_select(dmc_link_if_inst.doublet_select),
    .clock_divide_select(dmc_link_if_inst.clock_divide_select),
    .data_clock_skew_select(dmc_link_if_inst.data_clock_skew_select),
    .source_sync_clock_pos(dmc_link_if_inst.source_sync_clock_pos),
    .source_sync_clock_neg(dmc_link_if_inst.source_sync_clock_neg)
  );
  // ==================================================
  // clock and watchdog
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    report_and_stop();
  end
  // ==================================================
  // helpers
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask : tick
  task automatic chk(input string nm, input logic [GROUP_W-1:0] e, input logic [GROUP_W-1:0] g);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s expected %0h seen %0h", nm, e, g);
    end
  endtask : chk
  function automatic logic sig(input int s);
    case (s)
      0: return cal_busy;
      1: return term_ok;
      2: return cal_ready;
      3: return dmc_link_if_inst.source_sync_clock_pos;
      default: return grp_ready;
    endcase
  endfunction : sig
  // bounded wait; n tells how many cycles it took
  task automatic wt(input int s, input logic v, input int lim, output int n);
    n = 0;
    while (sig(s) !== v && n < lim) begin
      tick(1);
      n++;
    end
  endtask : wt
  function automatic logic [WORD_W-1:0] half2(input logic [WORD_W-1:0] w, input dmc_mode_t m);
    if (m == MODE_RZ) begin
      return MIDSCALE;
    end
    return (m == MODE_RF) ? ~w : w;
  endfunction : half2
  task automatic push(input logic [GROUP_W-1:0] g);
    int n;
    tick(1);
    grp_data = g;
    grp_valid = 1'b1;
    wt(4, 1'b1, 200, n);
    tick(1);
    grp_valid = 1'b0;
  endtask : push
  task automatic chk_rst();
    chk("mode", MODE_NRZ, mode);
    chk("valid", 1'b0, s_valid);
    chk("busy", 1'b0, cal_busy);
    chk("term", 1'b0, term_ok);
    chk("ready", 1'b1, grp_ready);
    chk("first", MIDSCALE, s_first);
    chk("locked", 1'b0, locked);
  endtask : chk_rst
  task automatic do_cal();
    int n;
    cal_en = 1'b1;
    wt(0, 1'b1, 20, n);
    wt(1, 1'b1, 100, n);
    chk("cal length", CALC, n);
    wt(2, 1'b1, 100, n);
    chk("cal ready", 1'b1, cal_ready);
  endtask : do_cal
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : report_and_stop
  // ==================================================
  // sequence
  initial begin
    int n;
    int p;
    logic [WORD_W-1:0] w;
    {rst_n, cal_en, req_rz, req_rf, div_sel, skew_sel, grp_valid} = 7'h00;
    ce = 1'b1;
    grp_data = GROUP_ZERO;
    err_total = 0;
    tests_run = 0;
    rows[0] = '{1'b0, 1'b0, 1'b0, 1'b0, 48'h000800FFF7FF, MODE_NRZ};
    rows[1] = '{1'b1, 1'b0, 1'b1, 1'b0, 48'h321CBA987654, MODE_RZ};
    rows[2] = '{1'b0, 1'b1, 1'b0, 1'b1, 48'hEDC0F1ABC135, MODE_RF};
    rows[3] = '{1'b1, 1'b1, 1'b1, 1'b1, 48'h111222333444, MODE_NRZ};
    tick(2);
    chk_rst();
    rst_n = 1'b1;
    do_cal();
    foreach (rows[i]) begin
      {req_rz, req_rf, div_sel, skew_sel} = {rows[i].rz, rows[i].rf, rows[i].div, rows[i].skew};
      tick(80);
      chk("mode", rows[i].mode, mode);
      chk("locked", 1'b1, locked);
      // high half then low half, both counted
      wt(3, 1'b0, 40, n);
      wt(3, 1'b1, 40, n);
      wt(3, 1'b0, 40, p);
      wt(3, 1'b1, 40, n);
      chk("period", rows[i].div ? 48'h8 : 48'h10, GROUP_W'(n + p));
      push(rows[i].grp);
      n = 0;
      while (s_first !== rows[i].grp[WORD_W-1:0] && n < 64) begin
        tick(1);
        n++;
      end
      for (int k = 0; k < NUM_CH; k++) begin
        w = rows[i].grp[k*WORD_W +: WORD_W];
        chk("first", w, s_first);
        chk("second", half2(w, rows[i].mode), s_second);
        tick(1);
      end
    end
    // trigger drop abandons calibration; buffer fills while pops are held off
    cal_en = 1'b0;
    tick(12);
    chk("term", 1'b0, term_ok);
    push(48'h0010020030AA);
    push(48'h0040050060BB);
    chk("full", 1'b0, grp_ready);
    cal_en = 1'b1;
    wt(0, 1'b1, 20, n);
    tick(3);
    cal_en = 1'b0;
    tick(30);
    chk("abort busy", 1'b0, cal_busy);
    chk("abort term", 1'b0, term_ok);
    do_cal();
    wt(4, 1'b1, 64, n);
    chk("drained", 1'b1, grp_ready);
    // enable low must freeze the converter end's sample and data clock
    ce = 1'b0;
    w = s_first;
    p = sig(3);
    tick(10);
    chk("frozen sample", w, s_first);
    chk("frozen clock", p, sig(3));
    ce = 1'b1;
    rst_n = 1'b0;
    tick(2);
    chk_rst();
    rst_n = 1'b1;
    tick(2);
    chk("valid after reset", 1'b1, s_valid);
    report_and_stop();
  end
endmodule : tb_dac_input_mux_mode_and_cal
`default_nettype wire
